// ---- mfrx_buffer.sv ----
// multi-frame receive buffer: collects up to eight timeslot answers into 32-byte slots of one buffer.
// assumes a receiver giving rx_start, rx_byte_valid/rx_byte and rx_end pulses while rx_enable is high,
// and a host on a plain strobe register port.

`timescale 1ns/1ps

module mfrx_buffer
	import mfrx_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	// host register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	output logic                   irq,
	// receiver side
	output logic                   rx_enable,
	input  wire logic              rx_start,
	input  wire logic              rx_byte_valid,
	input  wire logic [7:0]        rx_byte,
	input  wire logic              rx_end,
	input  wire logic              crc_ok,
	input  wire logic              collision,
	// transceive sequencing
	output logic                   wait_transmit_state
);

	// buffer word index of a slot and word position within it
	function automatic logic [5:0] word_index(input logic [2:0] slot, input logic [2:0] word_in_slot);
		word_index = {slot, word_in_slot};
	endfunction

	// strict decode of a register offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	mfrx_state_t       state;
	mfrx_state_t       next_state;

	logic              multi_frame_receive;
	logic [3:0]        frame_count;
	logic [7:0]        byte_idx;
	logic [7:0]        len_byte;
	logic [4:0]        gap_cnt;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	// no reset on the buffer: bytes between payload and status are undefined for software anyway
	logic [DATA_W-1:0] buf_mem [BUF_WORDS];

	// register decode
	logic              wr_ctrl;
	logic              wr_mask;
	logic              rd_irq_status;
	logic              buf_sel;
	logic              start_cmd;
	logic              idle_cmd;
	logic [DATA_W-1:0] next_rdata;

	// receive path
	logic              in_frame;
	logic              frame_begin;
	logic              frame_done;
	logic              len_too_long;
	logic              pay_we;
	logic [5:0]        pay_word;
	logic [4:0]        pay_lane;
	logic [5:0]        stat_word_idx;
	logic [DATA_W-1:0] status_word;
	logic              last_frame;
	logic [IRQ_W-1:0]  irq_events;
	logic [IRQ_W-1:0]  irq_clear;

	// exact decode, so a partly matching address never aliases a control register
	assign wr_ctrl       = wr && hit(addr, OFS_CTRL);
	assign wr_mask       = wr && hit(addr, OFS_IRQ_MASK);
	assign rd_irq_status = rd && hit(addr, OFS_IRQ_STATUS);
	// the whole upper half of the map is buffer, any aligned word in it
	assign buf_sel       = addr[ADDR_W-1] && (addr[1:0] == 2'h0);
	// start re-arms from any state, so software need not idle first
	assign start_cmd     = wr_ctrl && wdata[CTRL_START_BIT];
	assign idle_cmd      = wr_ctrl && wdata[CTRL_IDLE_BIT];

	assign in_frame      = (state == MFRX_FRAME);
	assign frame_begin   = (state == MFRX_ARMED) && rx_start;
	assign frame_done    = in_frame && rx_end;

	// oversize known from the length byte itself
	// while the length byte is on rx_byte it is not yet in len_byte
	assign len_too_long  = (byte_idx == 8'h00) ? (rx_byte > MAX_PAYLOAD) : (len_byte > MAX_PAYLOAD);
	// bytes from 28 on would overwrite the status word: counted, not stored
	assign pay_we        = in_frame && rx_byte_valid && (byte_idx < MAX_PAYLOAD) && !len_too_long;

	// slot chosen by frames already received
	assign pay_word      = word_index(frame_count[2:0], byte_idx[4:2]);
	assign pay_lane      = {byte_idx[1:0], 3'h0};
	// status in last word of slot
	assign stat_word_idx = word_index(frame_count[2:0], STATUS_WORD_IDX);

	// eighth frame ends the cycle
	// without multi-frame mode the first frame already ends the cycle
	assign last_frame    = (frame_count == (MAX_FRAMES - 4'h1)) || !multi_frame_receive;

	assign rx_enable           = (state == MFRX_ARMED) || in_frame;
	assign wait_transmit_state = (state == MFRX_WAIT_TX);

	// status is built from the byte count as it stands at the frame end
	mfrx_status_word u_status (
		.len_byte    (len_byte),
		.byte_count  (byte_idx),
		.crc_ok      (crc_ok),
		.collision   (collision),
		.status_word (status_word)
	);

	// sequencing of one multi-frame cycle
	// the one-hot code is also what software reads back in the status register
	always_comb begin
		next_state = state;
		case (state)
			MFRX_IDLE: begin
				next_state = MFRX_IDLE;
			end
			MFRX_ARMED: begin
				if (rx_start) begin
					next_state = MFRX_FRAME;
				end
			end
			MFRX_FRAME: begin
				if (rx_end) begin
					next_state = last_frame ? MFRX_WAIT_TX : MFRX_GAP;
				end
			end
			MFRX_GAP: begin
				if (gap_cnt == 5'h01) begin
					next_state = MFRX_ARMED;
				end
			end
			MFRX_WAIT_TX: begin
				next_state = MFRX_WAIT_TX;
			end
			default: begin
				next_state = MFRX_IDLE;
			end
		endcase
		// abort wins over everything but a fresh start
		if (idle_cmd) begin
			next_state = MFRX_IDLE;
		end
		if (start_cmd) begin
			next_state = MFRX_ARMED;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= MFRX_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// two clocks of 100 ns exceed two carrier periods and stay far below 2 us
	// gap counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_cnt <= 5'h00;
		end else if (frame_done) begin
			gap_cnt <= GAP_LOAD;
		end else if (gap_cnt != 5'h00) begin
			gap_cnt <= gap_cnt - 5'h01;
		end
	end

	// byte position and length byte of the frame in progress
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			byte_idx <= 8'h00;
			len_byte <= 8'h00;
		end else if (frame_begin) begin
			byte_idx <= 8'h00;
			len_byte <= 8'h00;
		end else if (in_frame && rx_byte_valid) begin
			if (byte_idx == 8'h00) begin
				len_byte <= rx_byte;
			end
			// saturate so an endless frame cannot wrap to a short count
			if (byte_idx != 8'hff) begin
				byte_idx <= byte_idx + 8'h01;
			end
		end
	end

	// counted per frame, so software may poll progress during the cycle
	// count cleared at cycle start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_count <= 4'h0;
		end else if (start_cmd) begin
			frame_count <= 4'h0;
		end else if (frame_done) begin
			frame_count <= frame_count + 4'h1;
		end
	end

	// slot storage, bytes past 28 never reach the status word
	always_ff @(posedge clk) begin
		if (pay_we) begin
			buf_mem[pay_word][pay_lane +: 8] <= rx_byte;
		end
		if (frame_done) begin
			buf_mem[stat_word_idx] <= status_word;
		end
	end

	// control register
	// start and idle are commands; only the mode bit is stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			multi_frame_receive <= 1'b0;
			irq_mask            <= '0;
		end else begin
			if (wr_ctrl) begin
				multi_frame_receive <= wdata[CTRL_MULTI_BIT];
			end
			// host may mask the receive interrupt
			if (wr_mask) begin
				irq_mask <= wdata[IRQ_W-1:0];
			end
		end
	end

	assign irq_events[IRQ_RX_BIT]  = frame_done;
	assign irq_events[IRQ_END_BIT] = frame_done && last_frame;
	assign irq_clear               = rd_irq_status ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}};

	// a read clears the status, but an event in the same cycle survives it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	// level output: stays high until software reads the status
	assign irq = |(irq_status & irq_mask);

	// read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = '0;
		if (buf_sel) begin
			next_rdata = buf_mem[addr[7:2]];
		end else if (hit(addr, OFS_CTRL)) begin
			next_rdata[CTRL_MULTI_BIT] = multi_frame_receive;
		end else if (hit(addr, OFS_STATUS)) begin
			next_rdata[STAT_COUNT_LSB +: 4] = frame_count;
			next_rdata[STAT_STATE_LSB +: 5] = state;
		end else if (hit(addr, OFS_IRQ_STATUS)) begin
			next_rdata[IRQ_W-1:0] = irq_status;
		end else if (hit(addr, OFS_IRQ_MASK)) begin
			next_rdata[IRQ_W-1:0] = irq_mask;
		end
	end

	// data stand only in the cycle after the strobe
	// zero elsewhere, so a stale word is never taken for a fresh one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= '0;
		end
	end

endmodule

// ---- mfrx_buffer_chk.sv ----
// assertion checker for mfrx_buffer, bound to every instance
// assumes rd and wr are never high together
`timescale 1ns/1ps
module mfrx_buffer_chk
	import mfrx_pkg::*;
(
	input wire logic		clk,
	input wire logic		rst,
	input wire logic [ADDR_W-1:0]	addr,
	input wire logic [DATA_W-1:0]	wdata,
	input wire logic		wr,
	input wire logic		rd,
	input wire logic [DATA_W-1:0]	rdata,
	input wire logic		irq,
	input wire logic		rx_enable,
	input wire logic		rx_start,
	input wire logic		rx_byte_valid,
	input wire logic [7:0]		rx_byte,
	input wire logic		rx_end,
	input wire logic		crc_ok,
	input wire logic		collision,
	input wire logic		wait_transmit_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire	ctl_wr = wr && addr == OFS_CTRL;
	wire	fin = rx_end && rx_enable && !wr;
	property p_gap;
		fin |=> !rx_enable ##1 (!rx_enable || $past(wr));
	endproperty
	a_gap: assert property (p_gap) else $error("re-arm gap too short");
	property p_rearm;
		fin ##1 !wr[*2] |=> rx_enable || wait_transmit_state;
	endproperty
	a_rearm: assert property (p_rearm) else $error("receiver not re-armed");
	property p_irq_src;
		$rose(irq) |-> $past(rx_end || wr);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq without cause");
	property p_rd_clr;
		rd && addr == OFS_IRQ_STATUS && !rx_end |=> !irq;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("status read kept irq");
	property p_idle;
		ctl_wr && wdata[CTRL_IDLE_BIT] && !wdata[CTRL_START_BIT] |=> !rx_enable && !wait_transmit_state;
	endproperty
	a_idle: assert property (p_idle) else $error("idle did not abort");
	property p_start;
		ctl_wr && wdata[CTRL_START_BIT] |=> rx_enable && !wait_transmit_state;
	endproperty
	a_start: assert property (p_start) else $error("start did not arm");
	property p_wtx;
		wait_transmit_state |-> !rx_enable && $past(rx_end || wait_transmit_state);
	endproperty
	a_wtx: assert property (p_wtx) else $error("receiving while waiting");
	property p_wtx_hold;
		wait_transmit_state && !ctl_wr |=> wait_transmit_state;
	endproperty
	a_wtx_hold: assert property (p_wtx_hold) else $error("left wait state");
endmodule
bind mfrx_buffer mfrx_buffer_chk u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .rx_enable, .rx_start,
	.rx_byte_valid, .rx_byte, .rx_end, .crc_ok, .collision, .wait_transmit_state);

// ---- mfrx_buffer_test.sv ----
// self-checking bench for mfrx_buffer; host port driven here, receiver side by mfrx_card
// assumes a 10 MHz clock and the register map of mfrx_pkg
`timescale 1ns/1ps
module mfrx_buffer_test
	import mfrx_pkg::*;
;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	logic [ADDR_W-1:0]	addr = '0;
	logic [DATA_W-1:0]	wdata = '0;
	logic [DATA_W-1:0]	d;
	logic			wr = 1'b0;
	logic			rd = 1'b0;
	logic [DATA_W-1:0]	rdata;
	logic			irq, rx_enable, rx_start, rx_byte_valid, rx_end, crc_ok, collision, wait_transmit_state;
	logic [7:0]		rx_byte;
	int			num_errors = 0;
	int			samples_checked = 0;
	always #50 clk = ~clk;
	mfrx_buffer dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .rx_enable, .rx_start, .rx_byte_valid,
		.rx_byte, .rx_end, .crc_ok, .collision, .wait_transmit_state);
	mfrx_card card (.clk, .rx_enable, .rx_start, .rx_byte_valid, .rx_byte, .rx_end, .crc_ok, .collision);
	task automatic chk(input logic [31:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wreg(input logic [8:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [8:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	function automatic logic [31:0] sw(input logic [7:0] len, n, input logic crc, coll);
		logic le, p, dt;
		le = len > MAX_PAYLOAD || n < len;
		p = n < len && len <= MAX_PAYLOAD;
		dt = !crc && len <= MAX_PAYLOAD;
		return {19'h0, le, dt | p | coll, coll, p, dt, n};
	endfunction
	task automatic t_multi();
		logic [7:0] len [8] = '{8'h04, 8'h05, 8'h1d, 8'h0a, 8'h06, 8'h1c, 8'h04, 8'h04};
		logic [7:0] n [8] = '{8'h04, 8'h05, 8'h03, 8'h05, 8'h06, 8'h1c, 8'h04, 8'h04};
		logic [7:0] crcs = 8'hfd;
		logic [7:0] colls = 8'h10;
		wreg(OFS_IRQ_MASK, 32'h3);
		wreg(OFS_CTRL, 32'h3);
		rreg(OFS_STATUS, d);
		chk(d, 32'h20, "armed with zero count");
		for (int i = 0; i < 8; i++) begin
			card.send(len[i], n[i], 8'(16 * i), crcs[i], colls[i]);
			#1 chk(irq, 1'b1, "irq per frame");
			rreg(OFS_IRQ_STATUS, d);
			chk(d, i == 7 ? 32'h3 : 32'h1, "irq status");
		end
		chk(wait_transmit_state, 1'b1, "wait transmit");
		rreg(OFS_STATUS, d);
		chk(d, 32'h108, "count and state");
		for (int i = 0; i < 8; i++) begin
			rreg(9'(OFS_BUF_BASE + 32 * i + 28), d);
			chk(d, sw(len[i], n[i], crcs[i], colls[i]), "slot status");
		end
		rreg(OFS_BUF_BASE, d);
		chk(d, 32'h03020104, "slot0 data");
		rreg(9'h120, d);
		chk(d, 32'h13121105, "slot1 data");
		$display("t_multi done");
	endtask
	task automatic t_abort();
		wreg(OFS_CTRL, 32'h3);
		rreg(OFS_STATUS, d);
		chk(d, 32'h20, "start clears count");
		card.send(8'h04, 8'h04, 8'h70, 1'b1, 1'b0);
		wreg(OFS_CTRL, 32'h5);
		#1 chk(rx_enable, 1'b0, "idle stops receiver");
		rreg(OFS_STATUS, d);
		chk(d, 32'h11, "idle with one frame");
		rreg(OFS_IRQ_STATUS, d);
		chk(d, 32'h1, "one frame flagged");
		$display("t_abort done");
	endtask
	task automatic t_single();
		wreg(OFS_IRQ_MASK, 32'h0);
		wreg(OFS_CTRL, 32'h2);
		card.send(8'h03, 8'h03, 8'h80, 1'b1, 1'b0);
		#1 chk(irq, 1'b0, "masked irq");
		rreg(OFS_IRQ_STATUS, d);
		chk(d, 32'h3, "single frame ends cycle");
		chk(wait_transmit_state, 1'b1, "single wait transmit");
		rreg(9'h010, d);
		chk(d, 32'h0, "unmapped read");
		wreg(OFS_CTRL, 32'h2);
		card.send(8'h1e, 8'h03, 8'h90, 1'b0, 1'b0);
		rreg(OFS_BUF_BASE, d);
		chk(d, 32'h73828103, "oversize frame stored no byte");
		rreg(9'h11c, d);
		chk(d, sw(8'h1e, 8'h03, 1'b0, 1'b0), "oversize status");
		$display("t_single done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_multi();
		t_abort();
		t_single();
		results();
	end
	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule

// ---- mfrx_card.sv ----
// behavioural card answering in timeslots on the receiver side
// assumes send() is called just after a rising clock edge
`timescale 1ns/1ps
module mfrx_card (
	input  wire logic	clk,
	input  wire logic	rx_enable,
	output logic		rx_start = 1'b0,
	output logic		rx_byte_valid = 1'b0,
	output logic [7:0]	rx_byte = 8'h5a,
	output logic		rx_end = 1'b0,
	output logic		crc_ok = 1'b0,
	output logic		collision = 1'b0
);
	task automatic send(input logic [7:0] len, input logic [7:0] n, input logic [7:0] base, input logic crc, coll);
		int i;
		i = 0;
		// answer only inside a timeslot, bounded so a dead receiver cannot hang us
		do begin
			@(posedge clk);
			i++;
		end while (!rx_enable && i < 40);
		rx_start <= 1'b1;
		@(posedge clk);
		rx_start <= 1'b0;
		for (i = 0; i < n; i++) begin
			rx_byte_valid <= 1'b1;
			rx_byte <= i ? 8'(base + i) : len;
			@(posedge clk);
		end
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_end <= 1'b1;
		crc_ok <= crc;
		collision <= coll;
		@(posedge clk);
		rx_end <= 1'b0;
		crc_ok <= ~crc;
		collision <= ~coll;
	endtask
endmodule

// ---- mfrx_status.sv ----
// package of shared constants and the per-frame status word builder for the multi-frame receive buffer.
// assumes the receiver delivers a finished frame's length byte, byte count, crc verdict and collision flag.

`timescale 1ns/1ps

package mfrx_pkg;

	// register bus
	localparam int          ADDR_W          = 9;
	localparam int          DATA_W          = 32;
	localparam logic [8:0]  OFS_CTRL        = 9'h000;
	localparam logic [8:0]  OFS_STATUS      = 9'h004;
	localparam logic [8:0]  OFS_IRQ_STATUS  = 9'h008;
	localparam logic [8:0]  OFS_IRQ_MASK    = 9'h00c;
	localparam logic [8:0]  OFS_BUF_BASE    = 9'h100;

	// control register bits
	localparam int          CTRL_MULTI_BIT  = 0;
	localparam int          CTRL_START_BIT  = 1;
	localparam int          CTRL_IDLE_BIT   = 2;

	// status register fields
	localparam int          STAT_COUNT_LSB  = 0;
	localparam int          STAT_STATE_LSB  = 4;

	// interrupt bits
	localparam int          IRQ_W           = 2;
	localparam int          IRQ_RX_BIT      = 0;
	localparam int          IRQ_END_BIT     = 1;

	// buffer geometry
	localparam int          BUF_WORDS       = 64;
	localparam int          SLOT_BYTES      = 32;
	localparam logic [7:0]  MAX_PAYLOAD     = 8'h1c;
	localparam logic [2:0]  STATUS_WORD_IDX = 3'h7;
	localparam logic [3:0]  MAX_FRAMES      = 4'h8;

	// per-slot status word fields
	localparam int          SW_COUNT_LSB    = 0;
	localparam int          SW_DATA_BIT     = 8;
	localparam int          SW_PROT_BIT     = 9;
	localparam int          SW_COLL_BIT     = 10;
	localparam int          SW_COMB_BIT     = 11;
	localparam int          SW_LEN_BIT      = 12;

	// receiver re-arm gap
	localparam int          CLK_PERIOD_PS   = 100000;
	localparam int          RF_PERIOD_PS    = 73746;
	localparam int          GAP_MIN_RF      = 2;
	localparam int          GAP_MAX_US      = 2;
	localparam int          GAP_MIN_CYCLES  = (GAP_MIN_RF * RF_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          GAP_MAX_CYCLES  = (GAP_MAX_US * 1000000) / CLK_PERIOD_PS;
	localparam logic [4:0]  GAP_LOAD        = 5'(GAP_MIN_CYCLES);

	typedef enum logic [4:0] {
		MFRX_IDLE    = 5'h01,
		MFRX_ARMED   = 5'h02,
		MFRX_FRAME   = 5'h04,
		MFRX_GAP     = 5'h08,
		MFRX_WAIT_TX = 5'h10
	} mfrx_state_t;

endpackage

module mfrx_status_word
	import mfrx_pkg::*;
(
	input  wire logic [7:0]        len_byte,
	input  wire logic [7:0]        byte_count,
	input  wire logic              crc_ok,
	input  wire logic              collision,
	output logic      [DATA_W-1:0] status_word
);

	logic too_long;
	logic too_short;
	logic data_integrity_flag;
	logic protocol_error_flag;
	logic length_error_flag;
	logic combined_error_flag;

	assign too_long            = len_byte > MAX_PAYLOAD;
	assign too_short           = byte_count < len_byte;
	assign data_integrity_flag = !crc_ok && !too_long;
	assign protocol_error_flag = too_short && !too_long;
	assign length_error_flag   = too_long || too_short;
	assign combined_error_flag = data_integrity_flag || protocol_error_flag || collision;

	always_comb begin
		status_word = '0;
		status_word[SW_COUNT_LSB +: 8] = byte_count;
		status_word[SW_DATA_BIT]       = data_integrity_flag;
		status_word[SW_PROT_BIT]       = protocol_error_flag;
		status_word[SW_COLL_BIT]       = collision;
		status_word[SW_COMB_BIT]       = combined_error_flag;
		status_word[SW_LEN_BIT]        = length_error_flag;
	end

endmodule
